// file: src/hsgfc_top.sv
// gate drive, fault latching, power good and serial link logic of the hot swap controller
`timescale 1ns/10ps
`include "hsgfc_params.svh"
module hsgfc_top (
    // clocks, reset, enable
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic scl_i,
    // comparator results
    input wire logic board_enable_n_i,
    input wire logic overvoltage_input_i,
    input wire logic undervoltage_rise_input_i,
    input wire logic undervoltage_fall_input_i,
    input wire logic uv_fault_reset_i,
    input wire logic soa_timer_node_i,
    input wire logic drain_low_i,
    input wire logic drain_fetbad_i,
    input wire logic gate_high_i,
    input wire logic output_above_threshold_i,
    input wire logic short_trip_i,
    input wire logic supply_input_ok_i,
    input wire logic internal_supply_ok_i,
    input wire logic eeprom_write_lock_i,
    input wire logic pg_watchdog_input_i,
    input wire logic external_fault_input_i,
    input wire logic current_limit_i,
    input wire logic [1:0] addr_strap_hi_i,
    input wire logic [1:0] addr_strap_lo_i,
    // configuration
    input wire hsgfc_pkg::hsgfc_cfg_s cfg_i,
    input wire logic eeprom_wr_req_i,
    input wire logic sda_in_i,
    // outputs
    output logic fet_drive_o,
    output logic fast_pulldown_o,
    output logic soa_discharge_o,
    output logic slew_ctrl_en_o,
    output logic [1:0] pg_io_o,
    output logic [1:0] pg_io_oe_o,
    output logic fault_irq_n_oe_o,
    output logic [6:0] faults_o,
    output logic vout_low_o,
    output logic eeprom_wr_ok_o,
    output logic enable_evt_tgl_o,
    output logic [3:0] addr_setting_o,
    output logic bcast_mode_o,
    output logic sda_out_oe_o,
    output logic [7:0] rx_byte_o
);
    ////////////////////////////////////////////////////////////////////////////////
    // input synchronisers
    localparam int NS = 17;
    logic [NS-1:0] raw, s1_r, s2_r;
    logic [3:0] st1_r, st2_r;
    hsgfc_pkg::hsgfc_cmp_s c;
    assign raw = {board_enable_n_i, overvoltage_input_i, undervoltage_rise_input_i,
                  undervoltage_fall_input_i, uv_fault_reset_i, soa_timer_node_i, drain_low_i,
                  drain_fetbad_i, gate_high_i, output_above_threshold_i, short_trip_i,
                  supply_input_ok_i, internal_supply_ok_i, eeprom_write_lock_i,
                  pg_watchdog_input_i, external_fault_input_i, current_limit_i};
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            // enable starts at its idle (disabled) level so no false enable edge follows reset
            s1_r <= {1'b1, 16'h0000};
            s2_r <= {1'b1, 16'h0000};
            st1_r <= '0;
            st2_r <= '0;
        end else if (ce_i) begin
            s1_r <= raw;
            s2_r <= s1_r;
            st1_r <= {addr_strap_hi_i, addr_strap_lo_i};
            st2_r <= st1_r;
        end
    end
    assign c = hsgfc_pkg::hsgfc_cmp_s'(s2_r);

    ////////////////////////////////////////////////////////////////////////////////
    // core control
    hsgfc_pkg::hsgfc_core_s q, d;
    logic cond_ok, en_fall, en_edge;
    logic [6:0] new_flt;
    always_comb begin
        d = q;
        en_fall = q.en_q & ~c.en_n;
        en_edge = q.en_q ^ c.en_n;
        // hysteresis: set when both high, clear only when both low
        if (c.undervoltage_rise_input && c.undervoltage_fall_input) begin
            d.uv_ok = 1'b1;
        end else if (!c.undervoltage_rise_input && !c.undervoltage_fall_input) begin
            d.uv_ok = 1'b0;
        end
        new_flt = '0;
        new_flt[`HSGFC_FLT_OV] = c.ov;
        new_flt[`HSGFC_FLT_OC] = c.tmr && q.fet;
        new_flt[`HSGFC_FLT_SHORT] = c.shrt;
        new_flt[`HSGFC_FLT_EXT] = c.ext_flt;
        new_flt[`HSGFC_FLT_UV] = q.uv_ok && !d.uv_ok;
        // fet-bad timer runs while drain stays high with gate on
        d.fb_cnt = (c.drn_bad && q.fet) ? q.fb_cnt + 24'h000001 : '0;
        new_flt[`HSGFC_FLT_FETBAD] = q.fb_cnt >= 24'(`HSGFC_FETBAD_CYC);
        d.pgi_cnt = (q.fet && !c.pg_watchdog_input) ? q.pgi_cnt + 24'h000001 : '0;
        new_flt[`HSGFC_FLT_PGI] = q.pgi_cnt >= 24'(`HSGFC_PGI_TIMEOUT_CYC);
        // clear loses to a fresh fault
        if (en_fall || c.uv_rst) begin
            d.faults = new_flt;
        end else begin
            d.faults = q.faults | new_flt;
        end
        d.en_q = c.en_n;
        if (en_edge) begin
            d.evt_tgl = ~q.evt_tgl;
        end
        cond_ok = !c.en_n && c.vin_ok && c.intv_ok && d.uv_ok && !c.ov && (d.faults == '0);
        case (q.st)
            hsgfc_pkg::HSGFC_ST_OFF: begin
                d.cnt = '0;
                if (cond_ok) begin
                    d.st = hsgfc_pkg::HSGFC_ST_DEB;
                end
            end
            hsgfc_pkg::HSGFC_ST_DEB: begin
                d.cnt = q.cnt + 24'h000001;
                if (!cond_ok) begin
                    d.st = hsgfc_pkg::HSGFC_ST_OFF;
                end else if (q.cnt >= 24'(`HSGFC_DEBOUNCE_CYC - 1)) begin
                    d.st = hsgfc_pkg::HSGFC_ST_ON;
                end
            end
            hsgfc_pkg::HSGFC_ST_ON: begin
                if (!cond_ok) begin
                    d.st = (d.faults != '0) ? hsgfc_pkg::HSGFC_ST_FLT : hsgfc_pkg::HSGFC_ST_OFF;
                end
            end
            hsgfc_pkg::HSGFC_ST_FLT: begin
                if (d.faults == '0) begin
                    d.st = hsgfc_pkg::HSGFC_ST_OFF;
                end
            end
            default: d.st = hsgfc_pkg::HSGFC_ST_OFF;
        endcase
        d.fet = (d.st == hsgfc_pkg::HSGFC_ST_ON) && cond_ok;
        d.pulldn = c.shrt;
        d.tmr_dis = !c.en_n;
        d.vout_low = !c.vout_ok;
        d.ee_wr_ok = !c.wp;
        // power good sequencing; overvoltage does not touch it
        if (q.fet && c.drn_lo && c.gate_hi && c.vout_ok) begin
            if (q.pg_cnt < 24'(4 * `HSGFC_DEBOUNCE_CYC)) begin
                d.pg_cnt = q.pg_cnt + 24'h000001;
            end
        end else if (!c.ov || !q.fet) begin
            d.pg_cnt = (c.ov && q.pg_cnt != '0) ? q.pg_cnt : '0;
        end
        d.pg1 = d.pg_cnt >= 24'(2 * `HSGFC_DEBOUNCE_CYC);
        d.pg2 = d.pg_cnt >= 24'(4 * `HSGFC_DEBOUNCE_CYC);
        d.slew_en = !(d.pg1);
        d.irq_n = ~|((d.faults & cfg_i.fault_mask) | (d.faults & cfg_i.adc_evt_mask));
    end
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q <= '{st: hsgfc_pkg::HSGFC_ST_OFF, en_q: 1'b1, irq_n: 1'b1, slew_en: 1'b1, default: '0};
        end else if (ce_i) begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // address strap decode: each strap is low, open or high
    logic [1:0] lvl0, lvl1;
    logic [3:0] addr_r;
    always_comb begin
        lvl0 = st2_r[0] ? 2'h0 : (st2_r[2] ? 2'h2 : 2'h1);
        lvl1 = st2_r[1] ? 2'h0 : (st2_r[3] ? 2'h2 : 2'h1);
    end
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            addr_r <= '0;
        end else if (ce_i) begin
            addr_r <= 4'(lvl1 * 3) + 4'(lvl0);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // serial link on the serial clock domain; scl edges define bit timing
    hsgfc_pkg::hsgfc_link_s l, ln;
    logic bcast;
    logic [7:0] div_lim;
    logic [2:0] mode_s_r;
    assign bcast = mode_s_r[2];
    always_ff @(posedge scl_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mode_s_r <= '0;
        end else begin
            mode_s_r <= {mode_s_r[1], mode_s_r[0], addr_r == `HSGFC_ADDR_BCAST};
        end
    end
    always_comb begin
        ln = l;
        case (cfg_i.brate_sel)
            2'h0: div_lim = `HSGFC_BRATE_DIV0;
            2'h1: div_lim = `HSGFC_BRATE_DIV1;
            2'h2: div_lim = `HSGFC_BRATE_DIV2;
            default: div_lim = `HSGFC_BRATE_DIV3;
        endcase
        ln.go_s = {l.go_s[1:0], cfg_i.bcast_go};
        if (!bcast) begin
            ln.rx = {l.rx[6:0], sda_in_i};
            ln.sda = l.sh[7];
            ln.sh = {l.sh[6:0], 1'b1};
        end else if (!l.busy) begin
            ln.sda = 1'b1;
            if (l.go_s[2] ^ l.go_s[1]) begin
                ln.busy = 1'b1;
                ln.sh = cfg_i.bcast_data;
                ln.bit_cnt = '0;
                ln.half = 1'b0;
                ln.div = '0;
            end
        end else if (l.div >= div_lim) begin
            ln.div = '0;
            // the last half-bit keeps its full width before the line idles again
            if (!l.half && l.bit_cnt == 4'h8) begin
                ln.busy = 1'b0;
                ln.sda = 1'b1;
            end else begin
                ln.half = ~l.half;
                ln.sda = l.half ? ~l.sh[7] : l.sh[7];
                if (l.half) begin
                    ln.sh = {l.sh[6:0], 1'b0};
                    ln.bit_cnt = l.bit_cnt + 4'h1;
                end
            end
        end else begin
            ln.div = l.div + 8'h01;
        end
    end
    always_ff @(posedge scl_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            l <= '{sda: 1'b1, sh: 8'hFF, default: '0};
        end else begin
            l <= ln;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // registered outputs
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            fet_drive_o <= 1'b0;
            fast_pulldown_o <= 1'b0;
            soa_discharge_o <= 1'b0;
            slew_ctrl_en_o <= 1'b1;
            pg_io_o <= '0;
            pg_io_oe_o <= '0;
            fault_irq_n_oe_o <= 1'b0;
            faults_o <= '0;
            vout_low_o <= 1'b0;
            eeprom_wr_ok_o <= 1'b0;
            enable_evt_tgl_o <= 1'b0;
            addr_setting_o <= '0;
            bcast_mode_o <= 1'b0;
        end else if (ce_i) begin
            fet_drive_o <= d.fet;
            fast_pulldown_o <= d.pulldn;
            soa_discharge_o <= d.tmr_dis;
            slew_ctrl_en_o <= d.slew_en;
            pg_io_o <= '0;
            pg_io_oe_o[0] <= !d.pg1;
            if (cfg_i.pg2_limit_indicator_sel && d.pg1) begin
                pg_io_oe_o[1] <= c.ilim;
            end else begin
                pg_io_oe_o[1] <= !d.pg2;
            end
            fault_irq_n_oe_o <= !d.irq_n;
            faults_o <= d.faults;
            vout_low_o <= d.vout_low;
            eeprom_wr_ok_o <= d.ee_wr_ok && eeprom_wr_req_i;
            enable_evt_tgl_o <= d.evt_tgl;
            addr_setting_o <= addr_r;
            bcast_mode_o <= addr_r == `HSGFC_ADDR_BCAST;
        end
    end
    // link outputs come from the link domain flops
    always_ff @(posedge scl_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sda_out_oe_o <= 1'b0;
            rx_byte_o <= '0;
        end else begin
            sda_out_oe_o <= !ln.sda;
            rx_byte_o <= ln.rx;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // assertions
    a_fet_off_disable: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        ce_i && c.en_n |=> !fet_drive_o) else $error("gate on while disabled");
    a_fet_lockout: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        ce_i && !c.vin_ok |=> !fet_drive_o) else $error("gate on in supply lockout");
    a_intv_lockout: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        ce_i && !c.intv_ok |=> !fet_drive_o) else $error("gate on in internal lockout");
    a_ov_fault_log: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        ce_i && c.ov |=> faults_o[`HSGFC_FLT_OV] && !fet_drive_o) else $error("ov not logged");
    a_short_pulldn: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        ce_i && c.shrt |=> fast_pulldown_o) else $error("short pulldown missing");
    a_tmr_discharge: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        ce_i |=> soa_discharge_o == !$past(c.en_n)) else $error("discharge mismatch");
    a_fet_needs_deb: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        $rose(fet_drive_o) |-> $past(q.st) == hsgfc_pkg::HSGFC_ST_DEB
        || $past(q.st) == hsgfc_pkg::HSGFC_ST_ON) else $error("gate on without debounce");
    a_irq_masked: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        fault_irq_n_oe_o |-> |(faults_o & (cfg_i.fault_mask | cfg_i.adc_evt_mask))
        || !ce_i) else $error("alert without enabled fault");
    a_pg_after_fet: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        $rose(q.pg1) |-> q.pg_cnt >= 24'(2 * `HSGFC_DEBOUNCE_CYC)) else $error("pg early");

    // event, flag and write lock outputs, uv hysteresis, the two fault timers and the limit flag
    a_evt_toggle: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        ce_i && (q.en_q ^ c.en_n) |=> enable_evt_tgl_o == !$past(q.evt_tgl)) else $error("enable edge lost");
    a_vout_low: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        ce_i |=> vout_low_o == !$past(c.vout_ok)) else $error("output low flag wrong");
    a_wp_block: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        ce_i && c.wp |=> !eeprom_wr_ok_o) else $error("write granted while locked");
    a_uv_hold: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        ce_i && q.uv_ok && (c.undervoltage_rise_input || c.undervoltage_fall_input) |=> q.uv_ok) else $error("uv dropped inside band");
    a_fetbad_flt: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        ce_i && q.fb_cnt >= 24'(`HSGFC_FETBAD_CYC) |=> faults_o[`HSGFC_FLT_FETBAD]) else $error("fet bad missed");
    a_pgi_off: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        ce_i && q.pgi_cnt >= 24'(`HSGFC_PGI_TIMEOUT_CYC) |=> !fet_drive_o) else $error("watchdog ignored");
    a_limit_flag: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        ce_i && cfg_i.pg2_limit_indicator_sel && d.pg1 |=> pg_io_oe_o[1] == $past(c.ilim)) else $error("limit flag");
    // the timers above only trip after long stable spans, so scenarios rarely reach them
endmodule

// file: inc/hsgfc_params.svh
// timing constants and encodings for the hot swap gate and fault control block
`ifndef HSGFC_PARAMS_SVH
`define HSGFC_PARAMS_SVH
`define HSGFC_CLK_PERIOD_NS 5
`define HSGFC_DEBOUNCE_US 50
`define HSGFC_DEBOUNCE_CYC ((`HSGFC_DEBOUNCE_US * 1000) / `HSGFC_CLK_PERIOD_NS)
`define HSGFC_PGI_TIMEOUT_US 100
`define HSGFC_PGI_TIMEOUT_CYC ((`HSGFC_PGI_TIMEOUT_US * 1000) / `HSGFC_CLK_PERIOD_NS)
`define HSGFC_FETBAD_US 20
`define HSGFC_FETBAD_CYC ((`HSGFC_FETBAD_US * 1000) / `HSGFC_CLK_PERIOD_NS)
`define HSGFC_CNT_W 24
`define HSGFC_FLT_OV 0
`define HSGFC_FLT_UV 1
`define HSGFC_FLT_OC 2
`define HSGFC_FLT_FETBAD 3
`define HSGFC_FLT_PGI 4
`define HSGFC_FLT_EXT 5
`define HSGFC_FLT_SHORT 6
`define HSGFC_FLT_W 7
`define HSGFC_ADDR_BCAST 4'h4
`define HSGFC_BRATE_DIV0 8'h03
`define HSGFC_BRATE_DIV1 8'h0B
`define HSGFC_BRATE_DIV2 8'h2F
`define HSGFC_BRATE_DIV3 8'hC2
`endif

// file: inc/hsgfc_pkg.sv
// types for the hot swap gate and fault control block
package hsgfc_pkg;
    typedef enum logic [1:0] {
        HSGFC_ST_OFF = 2'b00,
        HSGFC_ST_DEB = 2'b01,
        HSGFC_ST_ON = 2'b10,
        HSGFC_ST_FLT = 2'b11
    } hsgfc_state_e;
    // comparator results after synchronisation
    typedef struct packed {
        logic en_n;
        logic ov;
        logic undervoltage_rise_input;
        logic undervoltage_fall_input;
        logic uv_rst;
        logic tmr;
        logic drn_lo;
        logic drn_bad;
        logic gate_hi;
        logic vout_ok;
        logic shrt;
        logic vin_ok;
        logic intv_ok;
        logic wp;
        logic pg_watchdog_input;
        logic ext_flt;
        logic ilim;
    } hsgfc_cmp_s;
    typedef struct packed {
        logic [6:0] fault_mask;
        logic [6:0] adc_evt_mask;
        logic pg2_limit_indicator_sel;
        logic [1:0] brate_sel;
        logic [7:0] bcast_data;
        logic bcast_go;
    } hsgfc_cfg_s;
    typedef struct packed {
        hsgfc_state_e st;
        logic [23:0] cnt;
        logic [23:0] pg_cnt;
        logic [23:0] pgi_cnt;
        logic [23:0] fb_cnt;
        logic [6:0] faults;
        logic en_q;
        logic uv_ok;
        logic fet;
        logic pg1;
        logic pg2;
        logic irq_n;
        logic evt_tgl;
        logic slew_en;
        logic tmr_dis;
        logic pulldn;
        logic vout_low;
        logic ee_wr_ok;
    } hsgfc_core_s;
    typedef struct packed {
        logic [2:0] go_s;
        logic [7:0] sh;
        logic [3:0] bit_cnt;
        logic half;
        logic [7:0] div;
        logic busy;
        logic sda;
        logic [7:0] rx;
    } hsgfc_link_s;
endpackage

// file: testbench/hsgfc_host_model.sv
// host side model: drives the serial clock and data in, watches data out
`timescale 1ns/10ps
module hsgfc_host_model (
    // serial lines
    output logic scl_o,
    output logic sda_in_o,
    input wire logic sda_out_oe_i
);
    logic samp [0:255];

    initial begin
        scl_o = 1'h0;
        sda_in_o = 1'h1;
    end

    ////////////////////////////////////////////////////////////////////////////
    // serial clock, 48 ns, stands low between frames
    task automatic tick(input int n);
        repeat (n) begin
            #24 scl_o = 1'h1;
            #24 scl_o = 1'h0;
        end
    endtask

    // msb first, data moved only while the clock is low
    task automatic send_byte(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            sda_in_o = b[i];
            tick(1);
        end
        sda_in_o = 1'h1; // released line goes to its pull-up
    endtask

    // sda_out is open drain with a pull-up, so the line level is the inverse of the enable
    task automatic capture(input int n);
        for (int i = 0; i < n; i++) begin
            #23 samp[i] = ~sda_out_oe_i;
            #1 scl_o = 1'h1;
            #24 scl_o = 1'h0;
        end
    endtask
endmodule

// file: testbench/tb_hot_swap_gate_fault_control.sv
// self-checking bench for the hot swap gate and fault control block
`timescale 1ns/10ps
`include "hsgfc_params.svh"
module tb_hot_swap_gate_fault_control;
    localparam int DEB = `HSGFC_DEBOUNCE_CYC;
    logic clk, rst_n, ce, en_n, ov, undervoltage_rise_input, undervoltage_fall_input, uv_rst, tmr, dlo, dbad, ghi, oabv, shrt;
    logic vok, iok, wp, pg_watchdog_input, ext, ilim, eereq, scl, sda_in, sda_oe, fet, fpd, soa_dis;
    logic slew, irq_oe, vlow, ee_ok, evt, bmode, fh, sh;
    logic [1:0] strap_hi, strap_lo, pg_oe;
    logic [6:0] faults;
    logic [3:0] addr_set;
    logic [7:0] rx, mon, got, data;
    hsgfc_pkg::hsgfc_cfg_s cfg;
    int err_total;
    int checks;
    int h;

    assign mon = {bmode, slew, pg_oe, soa_dis, fpd, irq_oe, fet};

    hsgfc_top dut (
        .clk_sys_i(clk), .rst_n_i(rst_n), .ce_i(ce), .scl_i(scl), .board_enable_n_i(en_n),
        .overvoltage_input_i(ov), .undervoltage_rise_input_i(undervoltage_rise_input), .undervoltage_fall_input_i(undervoltage_fall_input),
        .uv_fault_reset_i(uv_rst), .soa_timer_node_i(tmr), .drain_low_i(dlo), .drain_fetbad_i(dbad),
        .gate_high_i(ghi), .output_above_threshold_i(oabv), .short_trip_i(shrt), .supply_input_ok_i(vok),
        .internal_supply_ok_i(iok), .eeprom_write_lock_i(wp), .pg_watchdog_input_i(pg_watchdog_input),
        .external_fault_input_i(ext), .current_limit_i(ilim), .addr_strap_hi_i(strap_hi),
        .addr_strap_lo_i(strap_lo), .cfg_i(cfg), .eeprom_wr_req_i(eereq), .sda_in_i(sda_in),
        .fet_drive_o(fet), .fast_pulldown_o(fpd), .soa_discharge_o(soa_dis), .slew_ctrl_en_o(slew),
        .pg_io_o(), .pg_io_oe_o(pg_oe), .fault_irq_n_oe_o(irq_oe), .faults_o(faults), .vout_low_o(vlow),
        .eeprom_wr_ok_o(ee_ok), .enable_evt_tgl_o(evt), .addr_setting_o(addr_set), .bcast_mode_o(bmode),
        .sda_out_oe_o(sda_oe), .rx_byte_o(rx)
    );

    hsgfc_host_model host (.scl_o(scl), .sda_in_o(sda_in), .sda_out_oe_i(sda_oe));

    initial begin
        clk = 1'h0;
        forever #2.5 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // bounded wait on one watched output, then compare
    task automatic wait_bit(input string name, input int k, input logic v, input int lim);
        for (int i = 0; i < lim && mon[k] !== v; i++) begin
            cyc(1);
        end
        chk(name, {7'h00, mon[k]}, {7'h00, v});
    endtask

    task automatic set_strap(input int s);
        strap_lo = {s / 3 == 0, s % 3 == 0};
        strap_hi = {s / 3 == 2, s % 3 == 2};
        cyc(4);
    endtask

    task automatic done(input string name);
        $display("test %s finished, mismatches so far %0d", name, err_total);
    endtask

    task automatic print_verdict();
        $display("comparisons %0d, mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // run needs about 84k core cycles; this cuts a hang short
    initial begin
        #500000;
        err_total++;
        print_verdict();
    end

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        {ce, en_n, ov, undervoltage_rise_input, undervoltage_fall_input, uv_rst, tmr, dlo, dbad, ghi, oabv, shrt, vok, iok, wp, pg_watchdog_input, ext, ilim, eereq} = 19'h6C048;
        cfg = '0;
        strap_hi = 2'h0;
        strap_lo = 2'h3;
        err_total = 0;
        checks = 0;
        rst_n = 1'h0;
        cyc(5);
        chk("fet_in_reset", fet, 1'h0);
        chk("slew_in_reset", slew, 1'h1);
        rst_n = 1'h1;
        for (int s = 0; s < 9; s++) begin
            set_strap(s);
            chk("addr_setting", addr_set, s[3:0]);
            chk("bcast_mode", bmode, s == 4);
        end
        done("strap decode");
        set_strap(8);
        host.send_byte(8'hA5);
        chk("rx_byte", rx, 8'hA5);
        set_strap(4);
        // the link side learns the mode only through its own clock edges
        host.tick(4);
        for (int k = 0; k < 2; k++) begin
            h = (k == 0) ? `HSGFC_BRATE_DIV0 + 1 : `HSGFC_BRATE_DIV1 + 1;
            data = (k == 0) ? 8'hC6 : 8'h3A;
            cfg.brate_sel = k[1:0];
            cfg.bcast_data = data;
            cfg.bcast_go = ~cfg.bcast_go;
            cyc(2);
            host.capture(17 * h + 6);
            for (int b = 0; b < 8; b++) begin
                fh = host.samp[3 + h + 2 * b * h + h / 2];
                sh = host.samp[3 + 2 * h + 2 * b * h + h / 2];
                chk("bcast_mid_bit_edge", {7'h00, fh ^ sh}, 8'h01);
                got[7 - b] = fh;
            end
            // either phase convention of the line code is accepted
            chk("bcast_byte", got, (got[7] === data[7]) ? data : ~data);
        end
        set_strap(8);
        done("serial link");
        en_n = 1'h0;
        cyc(4);
        chk("timer_discharge", soa_dis, 1'h1);
        chk("enable_event", evt, 1'h1);
        cyc(DEB + 50);
        chk("fet_intv_lockout", fet, 1'h0);
        iok = 1'h1;
        vok = 1'h0;
        cyc(DEB + 50);
        chk("fet_vin_lockout", fet, 1'h0);
        vok = 1'h1;
        cyc(1000);
        iok = 1'h0;
        cyc(2);
        iok = 1'h1;
        cyc(DEB - 10);
        chk("fet_debounce_restart", fet, 1'h0);
        wait_bit("fet_on", 0, 1'h1, 60);
        chk("vout_low", vlow, 1'h1);
        {dlo, ghi, oabv} = 3'h7;
        cyc(4);
        chk("vout_not_low", vlow, 1'h0);
        cyc(2 * DEB - 20);
        chk("pg1_early", pg_oe[0], 1'h1);
        wait_bit("pg1_good", 4, 1'h0, 80);
        cyc(2 * DEB - 60);
        chk("pg2_early", pg_oe[1], 1'h1);
        wait_bit("pg2_good", 5, 1'h0, 160);
        chk("slew_off", slew, 1'h0);
        done("startup");
        cfg.pg2_limit_indicator_sel = 1'h1;
        ilim = 1'h1;
        cyc(4);
        chk("limit_flag_on", pg_oe[1], 1'h1);
        ilim = 1'h0;
        cyc(4);
        chk("limit_flag_off", pg_oe[1], 1'h0);
        eereq = 1'h1;
        cyc(4);
        chk("ee_write_open", ee_ok, 1'h1);
        wp = 1'h1;
        cyc(4);
        chk("ee_write_locked", ee_ok, 1'h0);
        undervoltage_rise_input = 1'h0;
        cyc(8);
        chk("uv_hysteresis", fet, 1'h1);
        cfg.fault_mask = 7'h04;
        ov = 1'h1;
        cyc(4);
        chk("ov_gate_off", fet, 1'h0);
        chk("ov_fault", {1'h0, faults}, 8'h01);
        chk("ov_pg_kept", pg_oe, 2'h0);
        chk("ov_alert_masked", irq_oe, 1'h0);
        {ov, undervoltage_rise_input, uv_rst} = 3'h3;
        cyc(4);
        chk("uv_reset_clears", {1'h0, faults}, 8'h00);
        uv_rst = 1'h0;
        wait_bit("fet_back_on", 0, 1'h1, DEB + 60);
        tmr = 1'h1;
        cyc(4);
        chk("oc_gate_off", fet, 1'h0);
        chk("oc_fault", faults[`HSGFC_FLT_OC], 1'h1);
        chk("oc_alert", irq_oe, 1'h1);
        shrt = 1'h1;
        cyc(4);
        chk("short_pulldown", fpd, 1'h1);
        {tmr, shrt, en_n} = 3'h1;
        cyc(4);
        chk("disable_no_discharge", soa_dis, 1'h0);
        chk("disable_event", evt, 1'h0);
        en_n = 1'h0;
        cyc(4);
        chk("enable_clears", {1'h0, faults}, 8'h00);
        chk("enable_event_again", evt, 1'h1);
        done("faults");
        print_verdict();
    end
endmodule
